// ---- inc/epsw_pkg.sv ----
// Shared constants for the e-paper serial write port.
// Assumes one core clock domain and one link clock owned by the host.
package epsw_pkg;

  // Bits per transfer in each wire mode
  localparam int unsigned BITS_4W = 8;
  localparam int unsigned BITS_3W = 9;

  // Bit counter widths and their last positions
  localparam int unsigned CNT4_W = 3;
  localparam int unsigned CNT3_W = 4;
  localparam logic [2:0] CNT4_LAST = 3'h7;
  localparam logic [3:0] CNT3_LAST = 4'h8;
  localparam logic [2:0] CNT4_RST = 3'h0;
  localparam logic [3:0] CNT3_RST = 4'h0;

  // Shift register layout: bit 8 is the leading flag in 3-wire mode
  localparam int unsigned SHIFT_W = 9;
  localparam int unsigned FLAG_POS = 8;
  localparam logic [8:0] SHIFT_RST = 9'h000;

  // Strap levels
  localparam logic STRAP_4W = 1'b0;
  localparam logic STRAP_3W = 1'b1;

  // Flag or select level meaning display RAM
  localparam logic DC_RAM = 1'b1;

  // Reset values of core outputs
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [15:0] WCNT_RST = 16'h0000;

  // Core cycles after reset release before the strap is latched
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Number of busy sources
  localparam int unsigned BUSY_SRC = 3;

  typedef enum logic {
    EPSW_MODE_4W,
    EPSW_MODE_3W
  } epsw_mode_t;

  typedef enum logic [1:0] {
    EPSW_ST_STRAP,
    EPSW_ST_IDLE,
    EPSW_ST_FRAME
  } epsw_state_t;

endpackage : epsw_pkg

// ---- tb/epsw_host_model.sv ----
// Host side of the serial link: link clock, data, select lines.
// Assumes the bench calls send; link clock stands still between frames.
`timescale 1ns/1ps
module epsw_host_model (
  output logic o_sclk,
  output logic o_serial_data_in,
  output logic o_cs_b,
  output logic o_dc
);
  initial begin
    o_sclk = 1'b0;
    o_serial_data_in = 1'b0;
    o_cs_b = 1'b1;
    o_dc = 1'b0;
  end
  task automatic send(input logic [8:0] w, input int n, input logic dc);
    o_dc = dc;
    o_cs_b = 1'b0;
    #5;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_data_in = w[i];
      #16 o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
    end
    #16 o_cs_b = 1'b1;
    o_serial_data_in = ~o_serial_data_in;
    o_dc = 1'b0;
  endtask : send
endmodule : epsw_host_model

// ---- tb/epsw_port_assertions.sv ----
// Port checker for the serial write port, core clock domain.
// Assumes it is bound to epsw_port and sees only its ports.
`timescale 1ns/1ps
module epsw_port_assertions (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_bus_mode_strap,
  input wire logic i_wave_busy,
  input wire logic i_otp_busy,
  input wire logic i_temp_busy,
  input wire logic o_ram_we,
  input wire logic o_cmd_we,
  input wire logic [7:0] o_wr_data,
  input wire logic o_mode_3wire,
  input wire logic [15:0] o_frame_words,
  input wire logic o_busy,
  input wire logic o_busy_cmd_err
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  wire logic any_we = o_ram_we | o_cmd_we;
  wire logic busy_in = i_wave_busy | i_otp_busy | i_temp_busy;
  chk_we_onehot: assert property (!(o_ram_we && o_cmd_we))
    else $error("ram and command strobes together");
  chk_ram_pulse: assert property (o_ram_we |=> !o_ram_we)
    else $error("ram strobe longer than one cycle");
  chk_cmd_pulse: assert property (o_cmd_we |=> !o_cmd_we)
    else $error("command strobe longer than one cycle");
  chk_word_count: assert property (any_we |->
    o_frame_words == $past(o_frame_words) + 16'h0001)
    else $error("word count not stepped by one");
  chk_data_hold: assert property (!any_we |-> $stable(o_wr_data))
    else $error("write data moved without strobe");
  chk_busy_rise: assert property ($rose(busy_in) |-> ##[2:4] o_busy)
    else $error("busy output late to rise");
  chk_busy_fall: assert property ($fell(busy_in) |-> ##[2:4] !o_busy)
    else $error("busy output late to fall");
  chk_err_cause: assert property (o_busy_cmd_err |-> o_cmd_we && $past(o_busy))
    else $error("busy error flagged while idle");
  chk_err_missing: assert property (o_cmd_we && $past(o_busy) |-> o_busy_cmd_err)
    else $error("command while busy not flagged");
  chk_mode_hold: assert property (o_mode_3wire |=> o_mode_3wire)
    else $error("wire mode changed after latch");
  chk_mode_strap: assert property ($rose(o_mode_3wire) |-> $past(i_bus_mode_strap, 2))
    else $error("three wire mode without strap high");
  cover property (o_ram_we);
  cover property (o_cmd_we);
  cover property (o_busy_cmd_err);
endmodule : epsw_port_assertions

bind epsw_port epsw_port_assertions u_chk (.i_core_clk, .i_rst_b, .i_bus_mode_strap,
  .i_wave_busy, .i_otp_busy, .i_temp_busy, .o_ram_we, .o_cmd_we, .o_wr_data,
  .o_mode_3wire, .o_frame_words, .o_busy, .o_busy_cmd_err);

// ---- tb/epsw_port_tb_top.sv ----
// Bench for the serial write port: both wire modes, aborts, busy.
// Assumes the host model drives the link; core inputs move 1 ns after edges.
`timescale 1ns/1ps
module epsw_port_tb_top;
  logic clk, rst_b, strap, wave, otp, temp;
  logic sclk, serial_data_in, cs_b, dc;
  logic ram_we, cmd_we, mode, act, busy, err;
  logic [7:0] wr_data;
  logic [15:0] words;
  int n_mismatch = 0;
  int checks = 0;
  int n_err = 0;
  logic [8:0] q[$];
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  epsw_host_model u_host (.o_sclk(sclk), .o_serial_data_in(serial_data_in),
    .o_cs_b(cs_b), .o_dc(dc));
  epsw_port u_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_clock_lane_pin(sclk),
    .i_data_lane_pin(serial_data_in), .i_cs_b(cs_b), .i_dc_sel(dc), .i_bus_mode_strap(strap),
    .i_wave_busy(wave), .i_otp_busy(otp), .i_temp_busy(temp), .o_ram_we(ram_we),
    .o_cmd_we(cmd_we), .o_wr_data(wr_data), .o_mode_3wire(mode), .o_frame_active(act),
    .o_frame_words(words), .o_busy(busy), .o_busy_cmd_err(err));
  // Collect finished words mid cycle
  always @(negedge clk) begin
    if (ram_we || cmd_we) q.push_back({ram_we, wr_data});
    if (err) n_err++;
  end
  task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic reset(input logic s);
    @(posedge clk) #1 rst_b = 1'b0;
    strap = s;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (10) @(posedge clk);
    q.delete();
  endtask : reset
  task automatic xfer(input logic [8:0] w, input int n, input logic d);
    #1;
    fork
      u_host.send(w, n, d);
      begin
        repeat (8) @(posedge clk);
        #1 chk("frame active", {8'h00, act}, 9'h001);
      end
    join
    repeat (10) @(posedge clk);
    chk("frame idle", {8'h00, act}, 9'h000);
  endtask : xfer
  task automatic take(input logic [8:0] exp);
    logic [8:0] v;
    v = ~exp;
    if (q.size() > 0) v = q.pop_front();
    chk("word", v, exp);
  endtask : take
  task automatic t_four_wire();
    reset(1'b0);
    chk("mode", {8'h00, mode}, 9'h000);
    xfer(9'h0A5, 8, 1'b0);
    take(9'h0A5);
    xfer(9'h03C, 8, 1'b1);
    take(9'h13C);
    chk("frame words", words[8:0], 9'h001);
  endtask : t_four_wire
  task automatic t_abort();
    xfer(9'h015, 5, 1'b1);
    xfer(9'h181, 8, 1'b1);
    take(9'h181);
    xfer(9'h187, 9, 1'b0);
    take(9'h0C3);
    chk("extra words", 9'(q.size()), 9'h000);
  endtask : t_abort
  task automatic t_three_wire();
    reset(1'b1);
    chk("mode", {8'h00, mode}, 9'h001);
    xfer(9'h15A, 9, 1'b0);
    take(9'h15A);
    xfer(9'h0C3, 9, 1'b0);
    take(9'h0C3);
    xfer(9'h0FF, 8, 1'b0);
    chk("short word", 9'(q.size()), 9'h000);
  endtask : t_three_wire
  task automatic t_busy();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) #1 {temp, otp, wave} = 3'h1 << i;
      repeat (6) @(posedge clk);
      chk("busy", {8'h00, busy}, 9'h001);
      n_err = 0;
      xfer(9'h011, 9, 1'b0);
      xfer(9'h122, 9, 1'b0);
      take(9'h011);
      take(9'h122);
      chk("busy error", 9'(n_err), 9'h001);
      @(posedge clk) #1 {temp, otp, wave} = 3'h0;
      repeat (6) @(posedge clk);
      chk("idle", {8'h00, busy}, 9'h000);
    end
  endtask : t_busy
  initial begin
    rst_b = 1'b0;
    strap = 1'b0;
    {temp, otp, wave} = 3'h0;
    t_four_wire();
    t_abort();
    t_three_wire();
    t_busy();
    finish_test();
  end
  initial begin
    #50000;
    n_mismatch++;
    finish_test();
  end
endmodule : epsw_port_tb_top

// ---- verilog/epsw_port.sv ----
// Serial write port of an e-paper controller: link side and core side.
// Assumes the host owns the link clock, which may stop between frames.
//
// What this block does
// R1 - Strap fixes serial mode; no parallel mode
// R2 - Shift data in MSB first each rising edge
// R3 - 4-wire: sample select at eighth edge
// R4 - Write only; no serial read path exists
// R5 - 3-wire: flag then eight bits, nine edges
// R6 - 3-wire: flag one RAM, zero command
// R7 - 3-wire: host ties select pin low
// R8 - Transfers accepted only while select low
// R9 - Strap low 4-wire, high 3-wire
// R10 - Busy high during waveform, OTP, sensor
// R11 - Deselect clears bit counter, drops partial
`timescale 1ns/1ps
module epsw_port (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clock_lane_pin,
  input wire logic i_data_lane_pin,
  input wire logic i_cs_b,
  input wire logic i_dc_sel,
  input wire logic i_bus_mode_strap,
  input wire logic i_wave_busy,
  input wire logic i_otp_busy,
  input wire logic i_temp_busy,
  output logic o_ram_we,
  output logic o_cmd_we,
  output logic [7:0] o_wr_data,
  output logic o_mode_3wire,
  output logic o_frame_active,
  output logic [15:0] o_frame_words,
  output logic o_busy,
  output logic o_busy_cmd_err
);

  // ---------------- Link domain ----------------

  logic [epsw_pkg::SHIFT_W-1:0] shift_r;
  logic [epsw_pkg::SHIFT_W-1:0] shift_nxt;
  logic [epsw_pkg::CNT4_W-1:0] cnt4_r;
  logic [epsw_pkg::CNT3_W-1:0] cnt3_r;
  logic [7:0] hold4_r;
  logic hold4_dc_r;
  logic [7:0] hold3_r;
  logic hold3_flag_r;
  logic tog4_r;
  logic tog3_r;
  logic link_clr;
  logic link_rst;
  logic last4;
  logic last3;

  // R8 deselect or reset clears frame state; link clock is stopped then
  assign link_clr = i_cs_b | ~i_rst_b;
  assign link_rst = ~i_rst_b;

  // R2 MSB first shift
  assign shift_nxt = {shift_r[epsw_pkg::SHIFT_W-2:0], i_data_lane_pin};
  assign last4 = (cnt4_r == epsw_pkg::CNT4_LAST);
  assign last3 = (cnt3_r == epsw_pkg::CNT3_LAST);

  // R2 shift on rising link edge
  always_ff @(posedge i_clock_lane_pin or posedge link_rst) begin
    if (link_rst) begin
      shift_r <= epsw_pkg::SHIFT_RST;
    end else if (!i_cs_b) begin
      shift_r <= shift_nxt;
    end
  end

  // R11 counters cleared on deselect
  always_ff @(posedge i_clock_lane_pin or posedge link_clr) begin
    if (link_clr) begin
      cnt4_r <= epsw_pkg::CNT4_RST;
    end else if (last4) begin
      cnt4_r <= epsw_pkg::CNT4_RST;
    end else begin
      cnt4_r <= cnt4_r + 3'h1;
    end
  end

  // R11 nine-bit counter cleared too
  always_ff @(posedge i_clock_lane_pin or posedge link_clr) begin
    if (link_clr) begin
      cnt3_r <= epsw_pkg::CNT3_RST;
    end else if (last3) begin
      cnt3_r <= epsw_pkg::CNT3_RST;
    end else begin
      cnt3_r <= cnt3_r + 4'h1;
    end
  end

  // R3 select sampled with eighth bit
  always_ff @(posedge i_clock_lane_pin or posedge link_rst) begin
    if (link_rst) begin
      hold4_r <= epsw_pkg::DATA_RST;
      hold4_dc_r <= 1'b0;
      tog4_r <= 1'b0;
    end else if (!i_cs_b && last4) begin
      hold4_r <= shift_nxt[7:0];
      hold4_dc_r <= i_dc_sel;
      tog4_r <= ~tog4_r;
    end
  end

  // R5 word complete on ninth edge
  always_ff @(posedge i_clock_lane_pin or posedge link_rst) begin
    if (link_rst) begin
      hold3_r <= epsw_pkg::DATA_RST;
      hold3_flag_r <= 1'b0;
      tog3_r <= 1'b0;
    end else if (!i_cs_b && last3) begin
      hold3_r <= shift_nxt[7:0];
      hold3_flag_r <= shift_nxt[epsw_pkg::FLAG_POS];
      tog3_r <= ~tog3_r;
    end
  end

  // ---------------- Core domain ----------------

  logic tog4_s;
  logic tog3_s;
  logic cs_act_s;
  logic strap_s;
  logic busy_wave_s;
  logic busy_otp_s;
  logic busy_temp_s;

  epsw_sync u_sync_tog4 (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async(tog4_r),
    .o_sync(tog4_s)
  );

  epsw_sync u_sync_tog3 (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async(tog3_r),
    .o_sync(tog3_s)
  );

  epsw_sync u_sync_cs (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async(~i_cs_b),
    .o_sync(cs_act_s)
  );

  epsw_sync u_sync_strap (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_bus_mode_strap),
    .o_sync(strap_s)
  );

  epsw_sync u_sync_wave (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_wave_busy),
    .o_sync(busy_wave_s)
  );

  epsw_sync u_sync_otp (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_otp_busy),
    .o_sync(busy_otp_s)
  );

  epsw_sync u_sync_temp (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_temp_busy),
    .o_sync(busy_temp_s)
  );

  logic tog4_seen_r;
  logic tog3_seen_r;
  logic [1:0] wait_r;
  epsw_pkg::epsw_mode_t mode_r;
  epsw_pkg::epsw_state_t state_r;
  epsw_pkg::epsw_state_t state_nxt;
  logic ev4;
  logic ev3;
  logic word_ev;
  logic word_is_ram;
  logic [7:0] word_data;
  logic busy_any;
  logic wait_done;

  // Holding registers are stable for many core cycles after a toggle
  assign ev4 = (tog4_s != tog4_seen_r);
  assign ev3 = (tog3_s != tog3_seen_r);
  assign wait_done = (wait_r == epsw_pkg::STRAP_WAIT);

  // R9 strap level to mode
  // R1 only serial modes
  assign word_ev = (state_r != epsw_pkg::EPSW_ST_STRAP) &&
                   ((mode_r == epsw_pkg::EPSW_MODE_3W) ? ev3 : ev4);
  // R6 flag one goes to RAM
  // R7 select pin ignored in 3-wire
  assign word_is_ram = (mode_r == epsw_pkg::EPSW_MODE_3W) ?
                       (hold3_flag_r == epsw_pkg::DC_RAM) :
                       (hold4_dc_r == epsw_pkg::DC_RAM);
  assign word_data = (mode_r == epsw_pkg::EPSW_MODE_3W) ? hold3_r : hold4_r;
  assign busy_any = busy_wave_s | busy_otp_s | busy_temp_s;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      epsw_pkg::EPSW_ST_STRAP: begin
        if (wait_done) begin
          state_nxt = epsw_pkg::EPSW_ST_IDLE;
        end
      end
      epsw_pkg::EPSW_ST_IDLE: begin
        if (cs_act_s) begin
          state_nxt = epsw_pkg::EPSW_ST_FRAME;
        end
      end
      epsw_pkg::EPSW_ST_FRAME: begin
        if (!cs_act_s) begin
          state_nxt = epsw_pkg::EPSW_ST_IDLE;
        end
      end
      default: begin
        state_nxt = epsw_pkg::EPSW_ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state_r <= epsw_pkg::EPSW_ST_STRAP;
      wait_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      wait_r <= wait_done ? wait_r : wait_r + 2'h1;
    end
  end

  // R1 strap latched once after reset
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      mode_r <= epsw_pkg::EPSW_MODE_4W;
    end else if (state_r == epsw_pkg::EPSW_ST_STRAP && wait_done) begin
      mode_r <= (strap_s == epsw_pkg::STRAP_3W) ? epsw_pkg::EPSW_MODE_3W :
                                                  epsw_pkg::EPSW_MODE_4W;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      tog4_seen_r <= 1'b0;
      tog3_seen_r <= 1'b0;
    end else begin
      tog4_seen_r <= tog4_s;
      tog3_seen_r <= tog3_s;
    end
  end

  // R3 route to RAM or command
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_ram_we <= 1'b0;
      o_cmd_we <= 1'b0;
      o_wr_data <= epsw_pkg::DATA_RST;
    end else begin
      o_ram_we <= word_ev & word_is_ram;
      o_cmd_we <= word_ev & ~word_is_ram;
      if (word_ev) begin
        o_wr_data <= word_data;
      end
    end
  end

  // Words completed in the current frame
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_frame_words <= epsw_pkg::WCNT_RST;
    end else if (state_r == epsw_pkg::EPSW_ST_IDLE && cs_act_s) begin
      o_frame_words <= word_ev ? 16'h0001 : epsw_pkg::WCNT_RST;
    end else if (word_ev) begin
      o_frame_words <= o_frame_words + 16'h0001;
    end
  end

  // R10 busy from internal operations
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_busy <= 1'b0;
      o_busy_cmd_err <= 1'b0;
      o_frame_active <= 1'b0;
      o_mode_3wire <= 1'b0;
    end else begin
      o_busy <= busy_any;
      o_busy_cmd_err <= word_ev & ~word_is_ram & o_busy;
      o_frame_active <= cs_act_s;
      o_mode_3wire <= (mode_r == epsw_pkg::EPSW_MODE_3W);
    end
  end

  // R4 no output toward the link: write only

endmodule : epsw_port

// ---- verilog/epsw_sync.sv ----
// Two-flop level synchroniser into the core clock domain.
// Assumes the input is a level from another domain or a pin.
`timescale 1ns/1ps
module epsw_sync (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_async,
  output logic o_sync
);

  logic meta_r;
  logic sync_r;

  // First flop feeds only the second
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule : epsw_sync
